//--- rtl/tmds_aux_switch_consts.vh
`ifndef TMDS_AUX_SWITCH_CONSTS_VH
`define TMDS_AUX_SWITCH_CONSTS_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define ADDR_HS_MODES 8'h00
`define ADDR_AUX_MODES 8'h01
// fast reset word is a plain default: the fast path starts in standby
`define RST_HS_MODES 8'h00
// auxiliary switch leaves reset on, quad, source A
`define RST_AUX_MODES 8'h40

// ----------------------------------------
// field positions
// ----------------------------------------
`define EN_BIT 6
`define SM_HI 5
`define SM_LO 4
`define CH_HI 3
`define CH_LO 0

// ----------------------------------------
// bundling mode codes
// ----------------------------------------
`define MODE_QUAD 2'h0
`define MODE_DUAL 2'h1
`define MODE_SINGLE 2'h2
`define MODE_ILLEGAL 2'h3

// ----------------------------------------
// idle values
// ----------------------------------------
`define ROUTE_NONE 16'h0000
`define RD_UNMAPPED 8'h00

`endif

//--- rtl/tmds_aux_switch_select.v
`timescale 1ns/1ps
`include "tmds_aux_switch_consts.vh"

// Function
// R1 - fast mode code 00 is quad, 01 dual and 10 single bundling.
// R2 - a write of code 11 to the fast mode field leaves the held mode unchanged.
// R3 - in quad mode the two low select bits route a whole source to all four outputs.
// R4 - in dual mode the three low select bits pick a pair, even to outputs 1:0, odd to 3:2.
// R5 - in single mode the four select bits pick one of sixteen channels A0..D3.
// R6 - auxiliary enable 0 disconnects every auxiliary input, 1 connects the selected path.
// R7 - auxiliary mode code 00 is quad, 01 dual and 10 single bundling.
// R8 - a write of code 11 to the auxiliary mode field is discarded, old mode kept.
// R9 - fast enable 0 turns all fast channels off into standby, 1 turns them on.
// R10 - in auxiliary quad mode the two low select bits route a whole source to all four auxiliary outputs.
// R11 - fast and auxiliary selections act independently and reach the outputs one cycle after the register write.
module tmds_aux_switch_select
(
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // register write port
    input wire i_wr_en,
    input wire [7:0] i_wr_addr,
    input wire [7:0] i_wr_data,
    // register read port
    input wire [7:0] i_rd_addr,
    output reg [7:0] o_rd_data,
    // fast crossbar control: per output, one-hot over 16 input channels when on, all zero in standby
    output reg [15:0] o_fast_route_0,
    output reg [15:0] o_fast_route_1,
    output reg [15:0] o_fast_route_2,
    output reg [15:0] o_fast_route_3,
    output reg o_fast_channels_on,
    // auxiliary crossbar control
    output reg [15:0] o_side_route_0,
    output reg [15:0] o_side_route_1,
    output reg [15:0] o_side_route_2,
    output reg [15:0] o_side_route_3
);

// ----------------------------------------
// reset images
// ----------------------------------------
// fields are cut from the reset words so a new reset value needs one edit
localparam [7:0] RST_FAST = `RST_HS_MODES;
localparam [7:0] RST_SIDE = `RST_AUX_MODES;
localparam [0:0] RST_FAST_ON = RST_FAST[`EN_BIT];
localparam [1:0] RST_FAST_MODE = RST_FAST[`SM_HI:`SM_LO];
localparam [3:0] RST_FAST_SEL = RST_FAST[`CH_HI:`CH_LO];
localparam [0:0] RST_SIDE_ON = RST_SIDE[`EN_BIT];
localparam [1:0] RST_SIDE_MODE = RST_SIDE[`SM_HI:`SM_LO];
localparam [3:0] RST_SIDE_SEL = RST_SIDE[`CH_HI:`CH_LO];

// ----------------------------------------
// write decode
// ----------------------------------------
wire fast_wr;
wire side_wr;
wire wr_on;
wire [1:0] wr_mode;
wire [3:0] wr_sel;
wire wr_mode_legal;

// bit 7 of a write is not decoded at all
assign fast_wr = i_wr_en && (i_wr_addr == `ADDR_HS_MODES);
assign side_wr = i_wr_en && (i_wr_addr == `ADDR_AUX_MODES);
assign wr_on = i_wr_data[`EN_BIT];
assign wr_mode = i_wr_data[`SM_HI:`SM_LO];
assign wr_sel = i_wr_data[`CH_HI:`CH_LO];
// code 11 is refused for the mode field only, enable and select still land
assign wr_mode_legal = (wr_mode != `MODE_ILLEGAL); // R2 R8

// ----------------------------------------
// fast mode register
// ----------------------------------------
reg fast_channels_on;
reg [1:0] fast_bundling_mode;
reg [3:0] fast_source_select;

always @(posedge i_mclk or posedge i_rst)
begin
    if (i_rst)
    begin
        fast_channels_on <= RST_FAST_ON;
        fast_bundling_mode <= RST_FAST_MODE;
        fast_source_select <= RST_FAST_SEL;
    end
    else if (fast_wr) // R11
    begin
        fast_channels_on <= wr_on; // R9
        fast_source_select <= wr_sel;
        if (wr_mode_legal) // R2
            fast_bundling_mode <= wr_mode; // R1
    end
end

// ----------------------------------------
// auxiliary mode register
// ----------------------------------------
// own process, so a side write can never disturb the fast fields
reg side_on;
reg [1:0] side_bundling_mode;
reg [3:0] side_source_select;

always @(posedge i_mclk or posedge i_rst)
begin
    if (i_rst)
    begin
        side_on <= RST_SIDE_ON;
        side_bundling_mode <= RST_SIDE_MODE;
        side_source_select <= RST_SIDE_SEL;
    end
    else if (side_wr) // R11
    begin
        side_on <= wr_on; // R6
        side_source_select <= wr_sel;
        if (wr_mode_legal) // R8
            side_bundling_mode <= wr_mode; // R7
    end
end

// ----------------------------------------
// route decode
// ----------------------------------------
// input channel index = source*4 + lane, source A..D = 0..3
function [15:0] route;
    input [1:0] mode;
    input [3:0] sel;
    input integer out_lane;
    reg [3:0] idx;
    begin
        idx = 4'h0;
        case (mode)
            `MODE_QUAD: idx = {sel[1:0], out_lane[1:0]}; // R3 R10
            `MODE_DUAL: idx = {sel[2:0], out_lane[1]}; // R4
            `MODE_SINGLE: idx = sel; // R5
            default: idx = 4'h0;
        endcase
        route = 16'h0001 << idx;
    end
endfunction

// ----------------------------------------
// per-lane selects
// ----------------------------------------
// lanes packed 16 bits apart; a path that is off selects no input at all
wire [63:0] next_fast;
wire [63:0] next_side;

genvar lane;
generate
    for (lane = 0; lane < 4; lane = lane + 1)
    begin : g_lane
        // dual: lanes 0,1 carry the even channel, lanes 2,3 the odd one
        assign next_fast[lane * 16 +: 16] = fast_channels_on ?
            route(fast_bundling_mode, fast_source_select, lane) : `ROUTE_NONE; // R9
        assign next_side[lane * 16 +: 16] = side_on ?
            route(side_bundling_mode, side_source_select, lane) : `ROUTE_NONE; // R6
    end
endgenerate

// ----------------------------------------
// readback
// ----------------------------------------
wire [7:0] fast_word;
wire [7:0] side_word;
reg [7:0] next_rd_data;

// the unused top bit reads back as zero
assign fast_word = {1'b0, fast_channels_on, fast_bundling_mode, fast_source_select};
assign side_word = {1'b0, side_on, side_bundling_mode, side_source_select};

always @*
begin
    next_rd_data = `RD_UNMAPPED;
    case (i_rd_addr)
        `ADDR_HS_MODES: next_rd_data = fast_word; // R2
        `ADDR_AUX_MODES: next_rd_data = side_word; // R8
        default: next_rd_data = `RD_UNMAPPED;
    endcase
end

// ----------------------------------------
// registered outputs
// ----------------------------------------
// one cycle after the mode registers; costs a cycle, keeps every pin on a flop
always @(posedge i_mclk or posedge i_rst)
begin
    if (i_rst)
    begin
        o_fast_route_0 <= `ROUTE_NONE;
        o_fast_route_1 <= `ROUTE_NONE;
        o_fast_route_2 <= `ROUTE_NONE;
        o_fast_route_3 <= `ROUTE_NONE;
        o_fast_channels_on <= 1'b0;
    end
    else
    begin
        o_fast_route_0 <= next_fast[15:0]; // R9 R11
        o_fast_route_1 <= next_fast[31:16];
        o_fast_route_2 <= next_fast[47:32];
        o_fast_route_3 <= next_fast[63:48];
        o_fast_channels_on <= fast_channels_on; // R9
    end
end

// auxiliary outputs and readback, in a process of their own
always @(posedge i_mclk or posedge i_rst)
begin
    if (i_rst)
    begin
        o_side_route_0 <= `ROUTE_NONE;
        o_side_route_1 <= `ROUTE_NONE;
        o_side_route_2 <= `ROUTE_NONE;
        o_side_route_3 <= `ROUTE_NONE;
        o_rd_data <= `RD_UNMAPPED;
    end
    else
    begin
        o_side_route_0 <= next_side[15:0]; // R6 R11
        o_side_route_1 <= next_side[31:16];
        o_side_route_2 <= next_side[47:32];
        o_side_route_3 <= next_side[63:48];
        o_rd_data <= next_rd_data;
    end
end

endmodule

//--- tb/tmds_aux_switch_select_sva.sv
`timescale 1ns/1ps
module tmds_aux_switch_select_sva
(
    input wire i_mclk,
    input wire i_rst,
    input wire i_wr_en,
    input wire [7:0] i_wr_addr,
    input wire [7:0] i_wr_data,
    input wire [7:0] i_rd_addr,
    input wire [7:0] o_rd_data,
    input wire [15:0] o_fast_route_0,
    input wire [15:0] o_fast_route_1,
    input wire [15:0] o_fast_route_2,
    input wire [15:0] o_fast_route_3,
    input wire o_fast_channels_on,
    input wire [15:0] o_side_route_0,
    input wire [15:0] o_side_route_1,
    input wire [15:0] o_side_route_2,
    input wire [15:0] o_side_route_3
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    wire w0 = i_wr_en && i_wr_addr == 8'h00;
    wire w1 = i_wr_en && i_wr_addr == 8'h01;
    wire [6:0] d = i_wr_data[6:0];
    // readback must stay on the same index for the old and new value
    sequence s_bad(w, a);
        w && d[5:4] == 2'h3 && i_rd_addr == a ##1 i_rd_addr == a;
    endsequence
    a_fast_standby: assert property (w0 && !d[6] |-> ##2
        (o_fast_route_0 | o_fast_route_1 | o_fast_route_2 | o_fast_route_3) == 16'h0000)
        else $error("fast not off");
    a_fast_quad: assert property (w0 && d[6:4] == 3'h4 |-> ##2
        o_fast_route_1 == 16'h0001 << ($past(d[1:0], 2) * 4 + 1)) else $error("quad");
    a_fast_dual: assert property (w0 && d[6:4] == 3'h5 |-> ##2
        o_fast_route_2 == 16'h0001 << ($past(d[2:0], 2) * 2 + 1)) else $error("dual");
    a_fast_single: assert property (w0 && d[6:4] == 3'h6 |-> ##2
        o_fast_route_3 == 16'h0001 << $past(d[3:0], 2)) else $error("single");
    a_fast_keep: assert property (s_bad(w0, 8'h00) |=>
        o_rd_data[5:4] == $past(o_rd_data[5:4])) else $error("fast mode lost");
    a_side_off: assert property (w1 && !d[6] |-> ##2
        (o_side_route_0 | o_side_route_1 | o_side_route_2 | o_side_route_3) == 16'h0000)
        else $error("side not off");
    a_side_quad: assert property (w1 && d[6:4] == 3'h4 |-> ##2
        o_side_route_0 == 16'h0001 << ($past(d[1:0], 2) * 4)) else $error("side quad");
    a_side_keep: assert property (s_bad(w1, 8'h01) |=>
        o_rd_data[5:4] == $past(o_rd_data[5:4])) else $error("side mode lost");
    a_fast_flag: assert property (w0 |-> ##2
        o_fast_channels_on == $past(d[6], 2)) else $error("fast enable flag");
    a_side_on: assert property (w1 && d[6] |-> ##2
        $onehot(o_side_route_1)) else $error("side not on");
    a_side_single: assert property (w1 && d[6:4] == 3'h6 |-> ##2
        o_side_route_1 == 16'h0001 << $past(d[3:0], 2)) else $error("side single");
endmodule
bind tmds_aux_switch_select tmds_aux_switch_select_sva i_tmds_aux_switch_select_sva (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_wr_en(i_wr_en),
    .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data),
    .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data),
    .o_fast_route_0(o_fast_route_0),
    .o_fast_route_1(o_fast_route_1),
    .o_fast_route_2(o_fast_route_2),
    .o_fast_route_3(o_fast_route_3),
    .o_fast_channels_on(o_fast_channels_on),
    .o_side_route_0(o_side_route_0),
    .o_side_route_1(o_side_route_1),
    .o_side_route_2(o_side_route_2),
    .o_side_route_3(o_side_route_3)
);

//--- tb/test_tmds_aux_switch_select.sv
`timescale 1ns/1ps
module test_tmds_aux_switch_select;
    reg i_mclk = 1'b0, i_rst = 1'b1, i_wr_en = 1'b0;
    reg [7:0] i_wr_addr = 8'h00, i_wr_data = 8'h00, i_rd_addr = 8'h00, a, d;
    wire [7:0] o_rd_data;
    wire on;
    wire [63:0] fr, sr;
    reg [6:0] m [0:1];
    integer errors = 0, samples_checked = 0, i, k;
    always #12.5 i_mclk = ~i_mclk;
    tmds_aux_switch_select i_tmds_aux_switch_select (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr),
        .o_rd_data(o_rd_data), .o_fast_channels_on(on), .o_fast_route_0(fr[15:0]),
        .o_fast_route_1(fr[31:16]), .o_fast_route_2(fr[47:32]), .o_fast_route_3(fr[63:48]),
        .o_side_route_0(sr[15:0]), .o_side_route_1(sr[31:16]), .o_side_route_2(sr[47:32]),
        .o_side_route_3(sr[63:48]));
    function [15:0] rt(input [6:0] r, input integer n);
        rt = !r[6] ? 16'h0000 : r[5:4] == 2'h0 ? 16'h0001 << (r[1:0] * 4 + n)
            : r[5:4] == 2'h1 ? 16'h0001 << (r[2:0] * 2 + n / 2) : 16'h0001 << r[3:0];
    endfunction
    task chk(input [15:0] g, input [15:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e)
            begin
                errors = errors + 1;
                $display("[ERR] %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task verify;
        for (k = 0; k < 4; k = k + 1)
        begin
            chk(fr[k * 16 +: 16], rt(m[0], k));
            chk(sr[k * 16 +: 16], rt(m[1], k));
            chk(on, m[0][6]);
            chk(o_rd_data, i_rd_addr < 2 ? {1'b0, m[i_rd_addr[0]]} : 8'h00);
        end
    endtask
    task complete_run;
        begin
            if (errors == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial
    begin
        #60000;
        errors = errors + 1;
        complete_run;
    end
    initial
    begin
        m[0] = 7'h00;
        // auxiliary register leaves reset on, quad, source A
        m[1] = 7'h40;
        i = $urandom(72776);
        repeat (12) @(negedge i_mclk);
        i_rst = 1'b0;
        @(negedge i_mclk);
        verify;
        for (i = 0; i < 300; i = i + 1)
        begin
            if (i == 150)
            begin
                // mid-run reset: both registers fall back to their reset words
                i_rst = 1'b1;
                m[0] = 7'h00;
                m[1] = 7'h40;
                repeat (2) @(negedge i_mclk);
                i_rst = 1'b0;
                @(negedge i_mclk);
                verify;
            end
            // bit7 set in the last corner to show it is ignored
            a = i < 4 ? i[1] : $urandom % 3;
            d = i == 0 ? 8'h52 : i == 1 ? 8'h73 : i == 2 ? 8'h4f : i == 3 ? 8'hba : $urandom;
            i_wr_en = 1'b1;
            i_wr_addr = a;
            i_wr_data = d;
            // corners read back the register they write, so the keep checks fire
            i_rd_addr = i < 4 ? a : $urandom % 3;
            if (a < 2)
                m[a[0]] = {d[6], d[5:4] == 2'h3 ? m[a[0]][5:4] : d[5:4], d[3:0]};
            @(negedge i_mclk);
            i_wr_en = 1'b0;
            @(negedge i_mclk);
            verify;
        end
        complete_run;
    end
endmodule
